// ### inc/pfta_pkg.sv
// Shared constants and types for the program flash table access block
package pfta_pkg;
	// Bus geometry
	localparam int BUS_DATA_W = 32;
	localparam int BUS_ADDR_W = 5;
	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [4:0] OFS_FLASH_CONTROL = 5'h00;
	localparam logic [4:0] OFS_FLASH_UNLOCK_KEY = 5'h04;
	localparam logic [4:0] OFS_TABLE_LATCH = 5'h08;
	localparam logic [4:0] OFS_TABLE_POINTER_UPPER = 5'h0C;
	localparam logic [4:0] OFS_TABLE_POINTER_HIGH = 5'h10;
	localparam logic [4:0] OFS_TABLE_POINTER_LOW = 5'h14;
	localparam logic [4:0] OFS_TABLE_OP = 5'h18;
	////////////////////////////////////////////////////////////////////////////////
	// Control register fields and reset
	localparam int CTL_SINGLE_BIT = 5;
	localparam int CTL_ERASE_BIT = 4;
	localparam int CTL_FAULT_BIT = 3;
	localparam int CTL_ENABLE_BIT = 2;
	localparam int CTL_START_BIT = 1;
	localparam logic CTL_FIELD_RESET = 1'h0;
	// Table op register fields
	localparam int OP_MODE_LSB = 0;
	localparam int OP_STORE_BIT = 2;
	// Unlock key values
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	////////////////////////////////////////////////////////////////////////////////
	// Pointer and array geometry
	localparam int PTR_W = 22;
	localparam int SPACE_W = 21;
	localparam int HOLD_COUNT = 64;
	localparam int HOLD_IDX_W = 6;
	localparam int ROW_LSB = 6;
	localparam int BLOCK_LSB = 10;
	localparam logic [21:0] PTR_RESET = 22'h000000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	////////////////////////////////////////////////////////////////////////////////
	// Programming timer
	localparam int CLK_PERIOD_NS = 8;
	localparam int PROG_TIME_NS = 10000;
	localparam int ERASE_TIME_NS = 100000;
	localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	////////////////////////////////////////////////////////////////////////////////
	// Pointer update modes
	typedef enum logic [1:0] {
		PFTA_PTR_KEEP = 2'h0,
		PFTA_PTR_POST_INC = 2'h1,
		PFTA_PTR_POST_DEC = 2'h2,
		PFTA_PTR_PRE_INC = 2'h3
	} pfta_ptr_mode_type;
	// Sequencer states
	typedef enum logic [2:0] {
		PFTA_IDLE = 3'h0,
		PFTA_READ_ISSUE = 3'h1,
		PFTA_READ_WAIT = 3'h2,
		PFTA_READ_TAKE = 3'h3,
		PFTA_PROGRAM = 3'h4,
		PFTA_ERASE = 3'h5,
		PFTA_TIMED = 3'h6
	} pfta_state_type;
	// Request to the flash array
	typedef struct packed {
		logic [21:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
		logic erase;
	} pfta_mem_req_type;
endpackage : pfta_pkg

// ### src/pfta_top.sv
// Program flash table access: registers, table ops and self-timed program/erase
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pfta_top import pfta_pkg::*; #(
	parameter int PROG_CYCLES = PROG_CYCLES_DEF,
	parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
) (
	// Clock and resets
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic core_reset,
	// Avalon-MM slave
	input wire logic [BUS_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [BUS_DATA_W-1:0] writedata,
	output logic [BUS_DATA_W-1:0] readdata,
	output logic waitrequest,
	// Flash array
	output pfta_mem_req_type mem_req,
	input wire logic [15:0] mem_rdata,
	// Core halt
	output logic cpu_stall
);
	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	if (PROG_CYCLES < 1 || ERASE_CYCLES < 1) begin : g_bad_timer
		$error("pfta_top: timer counts must be at least one cycle");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State
	pfta_state_type state;
	pfta_state_type next_state;
	logic ctl_single;
	logic ctl_erase;
	logic ctl_fault;
	logic ctl_enable;
	logic ctl_start;
	logic [1:0] key_stage;
	logic [7:0] latch;
	logic [PTR_W-1:0] ptr;
	logic [7:0] hold [HOLD_COUNT];
	pfta_ptr_mode_type fetch_mode;
	logic [HOLD_IDX_W-1:0] prog_idx;
	logic [HOLD_IDX_W-1:0] prog_left;
	logic [31:0] timer;
	logic timed_erase;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire req = read | write;
	wire stall = (state != PFTA_IDLE) | ctl_start;
	wire wr_fire = write & ~waitrequest & byteenable[0];
	wire [7:0] wd = writedata[7:0];
	wire hit_ctl = address == OFS_FLASH_CONTROL;
	wire hit_key = address == OFS_FLASH_UNLOCK_KEY;
	wire hit_latch = address == OFS_TABLE_LATCH;
	wire hit_upper = address == OFS_TABLE_POINTER_UPPER;
	wire hit_high = address == OFS_TABLE_POINTER_HIGH;
	wire hit_low = address == OFS_TABLE_POINTER_LOW;
	wire hit_op = address == OFS_TABLE_OP;
	wire wr_ctl = wr_fire & hit_ctl;
	wire wr_key = wr_fire & hit_key;
	wire wr_op = wr_fire & hit_op;
	// Launching while stalled is impossible: the bus is held off
	wire next_wait = ~(req & waitrequest & ~stall);

	////////////////////////////////////////////////////////////////////////////////
	// Read mux
	wire [7:0] ctl_view = {2'b00, ctl_single, ctl_erase, ctl_fault, ctl_enable, ctl_start, 1'b0};
	wire [7:0] upper_view = {2'b00, ptr[21:16]};
	wire [7:0] rd_byte = hit_ctl ? ctl_view :
		hit_latch ? latch :
		hit_upper ? upper_view :
		hit_high ? ptr[15:8] :
		hit_low ? ptr[7:0] :
		8'h00;
	wire rd_launch = read & waitrequest & ~stall;

	////////////////////////////////////////////////////////////////////////////////
	// Start, unlock and fault decisions
	wire start_req = wr_ctl & wd[CTL_START_BIT] & ~ctl_start;
	wire unlocked = key_stage == 2'h2;
	wire launch = start_req & ctl_enable & unlocked;
	wire improper = start_req & ~(ctl_enable & unlocked);
	wire [1:0] next_key_stage = wr_key && wd == KEY_FIRST ? 2'h1 :
		wr_key && wd == KEY_SECOND && key_stage == 2'h1 ? 2'h2 :
		wr_fire ? 2'h0 :
		key_stage;
	wire op_done = state == PFTA_TIMED && timer == 32'h1;
	wire erase_done = op_done & timed_erase;

	////////////////////////////////////////////////////////////////////////////////
	// Pointer arithmetic
	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic up);
		logic [SPACE_W-1:0] low;
		low = up ? p[SPACE_W-1:0] + 21'h000001 : p[SPACE_W-1:0] - 21'h000001;
		ptr_step = {p[PTR_W-1], low};
	endfunction : ptr_step

	function automatic logic [PTR_W-1:0] ptr_post(input logic [PTR_W-1:0] p, input pfta_ptr_mode_type m);
		ptr_post = m == PFTA_PTR_POST_INC ? ptr_step(p, 1'b1) :
			m == PFTA_PTR_POST_DEC ? ptr_step(p, 1'b0) : p;
	endfunction : ptr_post

	wire pfta_ptr_mode_type op_mode = pfta_ptr_mode_type'(wd[OP_MODE_LSB+:2]);
	wire op_store = wr_op & wd[OP_STORE_BIT];
	wire op_fetch = wr_op & ~wd[OP_STORE_BIT];
	wire [PTR_W-1:0] eff_ptr = op_mode == PFTA_PTR_PRE_INC ? ptr_step(ptr, 1'b1) : ptr;
	wire [PTR_W-1:0] next_ptr = wr_fire && hit_upper ? {wd[5:0], ptr[15:0]} :
		wr_fire && hit_high ? {ptr[21:16], wd, ptr[7:0]} :
		wr_fire && hit_low ? {ptr[21:8], wd} :
		op_store ? ptr_post(eff_ptr, op_mode) :
		op_fetch ? eff_ptr :
		state == PFTA_READ_TAKE ? ptr_post(ptr, fetch_mode) :
		ptr;
	wire [7:0] fetched = ptr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
	wire [7:0] next_latch = wr_fire && hit_latch ? wd :
		state == PFTA_READ_TAKE ? fetched :
		latch;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	wire [HOLD_IDX_W-1:0] pair_base = {ptr[ROW_LSB-1:1], 1'b0};
	always_comb begin
		next_state = state;
		unique case (state)
			PFTA_IDLE: begin
				if (launch) begin
					next_state = ctl_erase ? PFTA_ERASE : PFTA_PROGRAM;
				end else if (op_fetch) begin
					next_state = PFTA_READ_ISSUE;
				end
			end
			PFTA_READ_ISSUE: next_state = PFTA_READ_WAIT;
			PFTA_READ_WAIT: next_state = PFTA_READ_TAKE;
			PFTA_READ_TAKE: next_state = PFTA_IDLE;
			PFTA_PROGRAM: begin
				if (prog_left == '0) begin
					next_state = PFTA_TIMED;
				end
			end
			PFTA_ERASE: next_state = PFTA_TIMED;
			PFTA_TIMED: begin
				if (timer == 32'h1) begin
					next_state = PFTA_IDLE;
				end
			end
			default: next_state = PFTA_IDLE;
		endcase
		if (core_reset) begin
			next_state = PFTA_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= PFTA_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave flops
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			waitrequest <= 1'b1;
			readdata <= '0;
		end else begin
			waitrequest <= next_wait;
			readdata <= rd_launch ? {24'h000000, rd_byte} : readdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_single <= CTL_FIELD_RESET;
			ctl_erase <= CTL_FIELD_RESET;
			ctl_enable <= CTL_FIELD_RESET;
			ctl_fault <= CTL_FIELD_RESET;
			ctl_start <= CTL_FIELD_RESET;
			key_stage <= 2'h0;
		end else if (core_reset) begin
			// Fault flag deliberately survives so an aborted cycle stays visible
			ctl_single <= CTL_FIELD_RESET;
			ctl_erase <= CTL_FIELD_RESET;
			ctl_enable <= CTL_FIELD_RESET;
			ctl_start <= CTL_FIELD_RESET;
			key_stage <= 2'h0;
		end else begin
			ctl_single <= wr_ctl ? wd[CTL_SINGLE_BIT] : ctl_single;
			ctl_erase <= wr_ctl ? wd[CTL_ERASE_BIT] : (erase_done ? 1'b0 : ctl_erase);
			ctl_enable <= wr_ctl ? wd[CTL_ENABLE_BIT] : ctl_enable;
			ctl_fault <= (launch | improper) ? 1'b1 :
				op_done ? 1'b0 :
				wr_ctl ? wd[CTL_FAULT_BIT] : ctl_fault;
			ctl_start <= launch ? 1'b1 : (op_done ? 1'b0 : ctl_start);
			key_stage <= next_key_stage;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Latch, pointer and fetch mode
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			latch <= BYTE_RESET;
			ptr <= PTR_RESET;
			fetch_mode <= PFTA_PTR_KEEP;
		end else begin
			latch <= next_latch;
			ptr <= next_ptr;
			fetch_mode <= op_fetch ? op_mode : fetch_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Holding registers, never cleared by programming
	for (genvar i = 0; i < HOLD_COUNT; i++) begin : g_hold
		wire hit = op_store && eff_ptr[HOLD_IDX_W-1:0] == HOLD_IDX_W'(i);
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				hold[i] <= BYTE_RESET;
			end else begin
				hold[i] <= hit ? latch : hold[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Program walk and timer
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			prog_idx <= '0;
			prog_left <= '0;
			timer <= 32'h0;
			timed_erase <= 1'b0;
		end else begin
			if (launch) begin
				prog_idx <= ctl_single ? pair_base : '0;
				prog_left <= ctl_single ? HOLD_IDX_W'(1) : HOLD_IDX_W'(HOLD_COUNT - 1);
				timed_erase <= ctl_erase;
			end else if (state == PFTA_PROGRAM) begin
				prog_idx <= prog_idx + HOLD_IDX_W'(1);
				prog_left <= prog_left - HOLD_IDX_W'(1);
			end
			if (state == PFTA_PROGRAM && next_state == PFTA_TIMED) begin
				timer <= 32'(PROG_CYCLES);
			end else if (state == PFTA_ERASE && next_state == PFTA_TIMED) begin
				timer <= 32'(ERASE_CYCLES);
			end else if (state == PFTA_TIMED) begin
				timer <= timer - 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flash array request, one cycle behind the sequencer
	wire [PTR_W-1:0] prog_addr = {ptr[PTR_W-1:ROW_LSB], prog_idx};
	wire [PTR_W-1:0] erase_addr = {ptr[PTR_W-1:BLOCK_LSB], 10'h000};
	wire in_prog = state == PFTA_PROGRAM;
	wire in_erase = state == PFTA_ERASE;
	wire in_read = state == PFTA_READ_ISSUE;
	wire [PTR_W-1:0] next_mem_addr = in_prog ? prog_addr :
		in_erase ? erase_addr :
		in_read ? ptr : mem_req.addr;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mem_req <= '0;
			cpu_stall <= 1'b0;
		end else begin
			mem_req.addr <= next_mem_addr;
			mem_req.rd <= in_read & ~core_reset;
			mem_req.wr <= in_prog & ~core_reset;
			mem_req.wdata <= hold[prog_idx];
			mem_req.erase <= in_erase & ~core_reset;
			cpu_stall <= next_state == PFTA_PROGRAM || next_state == PFTA_ERASE || next_state == PFTA_TIMED;
		end
	end
endmodule : pfta_top

// ### dv/pfta_sva.sv
// Port checker for the program flash table access block
`timescale 1ns/1ps
module pfta_sva import pfta_pkg::*; (
	// Clock and resets
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic core_reset,
	// Bus and core
	input wire logic write,
	input wire logic [BUS_DATA_W-1:0] readdata,
	input wire logic waitrequest,
	input wire logic cpu_stall,
	// Flash array
	input wire pfta_mem_req_type mem_req
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////////////
	property p_bus_held; cpu_stall |-> waitrequest; endproperty
	a_bus_held: assert property (p_bus_held) else $error("Bus answered during stall");
	property p_erase_align; mem_req.erase |-> mem_req.addr[9:0] == 10'h000; endproperty
	a_erase_align: assert property (p_erase_align) else $error("Erase address not block aligned");
	property p_erase_stall; mem_req.erase |-> cpu_stall; endproperty
	a_erase_stall: assert property (p_erase_stall) else $error("Erase without stall");
	property p_erase_pulse; mem_req.erase |=> !mem_req.erase; endproperty
	a_erase_pulse: assert property (p_erase_pulse) else $error("Erase pulse too long");
	property p_wr_stall; mem_req.wr |-> cpu_stall; endproperty
	a_wr_stall: assert property (p_wr_stall) else $error("Program write without stall");
	property p_wr_step; mem_req.wr && $past(mem_req.wr) |-> mem_req.addr == $past(mem_req.addr) + 22'h000001; endproperty
	a_wr_step: assert property (p_wr_step) else $error("Program address not stepping");
	property p_rd_pulse; mem_req.rd |-> !cpu_stall ##1 !mem_req.rd; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("Fetch strobe wrong");
	// Start is only reachable through a completed bus write
	property p_launch; $rose(cpu_stall) |-> $past(write, 1) || $past(write, 2); endproperty
	a_launch: assert property (p_launch) else $error("Stall without start write");
	property p_stall_min; disable iff (!arst_n || core_reset) $rose(cpu_stall) |-> cpu_stall[*4]; endproperty
	a_stall_min: assert property (p_stall_min) else $error("Timed cycle too short");
	property p_upper_zero; readdata[31:8] == 24'h000000; endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("Read data upper lanes set");
endmodule : pfta_sva
////////////////////////////////////////////////////////////////////////////////
bind pfta_top pfta_sva u_sva (.mclk(mclk), .arst_n(arst_n), .core_reset(core_reset), .write(write),
	.readdata(readdata), .waitrequest(waitrequest), .cpu_stall(cpu_stall), .mem_req(mem_req));

// ### dv/pfta_flash_model.sv
// Behavioural flash array seen by the block's memory port
`timescale 1ns/1ps
module pfta_flash_model import pfta_pkg::*; (
	// Clock
	input wire logic mclk,
	// Memory port
	input wire pfta_mem_req_type mem_req,
	output logic [15:0] mem_rdata,
	// Observation
	output logic [15:0] wr_count,
	output logic [15:0] erase_count,
	output logic [21:0] last_addr,
	output logic [21:0] erase_addr,
	output logic [7:0] last_data
);
	initial begin
		mem_rdata = 16'h0000;
		wr_count = 16'h0000;
		erase_count = 16'h0000;
	end
	always @(posedge mclk) begin
		// Word contents depend on the top bit and address bits 7:1 only
		if (mem_req.rd) mem_rdata <= {mem_req.addr[21], mem_req.addr[7:1], ~mem_req.addr[21], mem_req.addr[7:1]};
		else mem_rdata <= ~mem_rdata; // Stale data is inverted on every cycle without a read
		if (mem_req.wr) begin
			wr_count <= wr_count + 16'h0001;
			last_addr <= mem_req.addr;
			last_data <= mem_req.wdata;
		end
		if (mem_req.erase) begin
			erase_count <= erase_count + 16'h0001;
			erase_addr <= mem_req.addr;
		end
	end
endmodule : pfta_flash_model

// ### dv/pfta_bench.sv
// Self-checking bench for the program flash table access block
`timescale 1ns/1ps
module pfta_bench import pfta_pkg::*;;
	logic mclk;
	logic arst_n = 1'b0;
	logic core_reset = 1'b0;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = 4'hF;
	logic [31:0] writedata = 32'h00000000;
	logic [31:0] readdata;
	logic waitrequest;
	pfta_mem_req_type mem_req;
	logic [15:0] mem_rdata, wr_count, erase_count;
	logic [21:0] last_addr, erase_addr;
	logic [7:0] last_data;
	int miscompares = 0;
	int compares = 0;
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	pfta_top #(.PROG_CYCLES(3), .ERASE_CYCLES(5)) dut (.mclk(mclk), .arst_n(arst_n), .core_reset(core_reset),
		.address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .mem_req(mem_req), .mem_rdata(mem_rdata), .cpu_stall());
	pfta_flash_model u_flash (.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata), .wr_count(wr_count),
		.erase_count(erase_count), .last_addr(last_addr), .erase_addr(erase_addr), .last_data(last_data));
	////////////////////////////////////////////////////////////////////////////////
	task results;
		$display("Compares %0d, miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Request held until waitrequest is sampled low
	task bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge mclk);
		address <= a;
		writedata <= {24'h000000, d};
		write <= wr;
		read <= !wr;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 5000);
		q = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 5000) begin
			miscompares++;
			results();
		end
	endtask : bus
	task w(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : w
	task r(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		check({24'h000000, q}, {24'h000000, e});
	endtask : r
	task unlock;
		w(OFS_FLASH_UNLOCK_KEY, KEY_FIRST);
		w(OFS_FLASH_UNLOCK_KEY, KEY_SECOND);
	endtask : unlock
	task set_ptr(input logic [21:0] p);
		w(OFS_TABLE_POINTER_UPPER, {2'h0, p[21:16]});
		w(OFS_TABLE_POINTER_HIGH, p[15:8]);
		w(OFS_TABLE_POINTER_LOW, p[7:0]);
	endtask : set_ptr
	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		r(OFS_FLASH_CONTROL, 8'h00);
		w(OFS_FLASH_UNLOCK_KEY, KEY_FIRST);
		r(OFS_FLASH_UNLOCK_KEY, 8'h00);
		w(OFS_FLASH_CONTROL, 8'hC1);
		r(OFS_FLASH_CONTROL, 8'h00);
		w(OFS_TABLE_POINTER_UPPER, 8'hFF);
		r(OFS_TABLE_POINTER_UPPER, 8'h3F);
		w(OFS_TABLE_LATCH, 8'h96);
		byteenable <= 4'hE;
		w(OFS_TABLE_LATCH, 8'h11);
		byteenable <= 4'hF;
		r(OFS_TABLE_LATCH, 8'h96);
		r(5'h1C, 8'h00);
	endtask : t_regs
	// Each mode from a pointer at the 21-bit wrap point
	task t_fetch;
		logic [21:0] p, a;
		logic [1:0] m;
		p = 22'h3FFFFF;
		set_ptr(p);
		for (int i = 0; i < 4; i++) begin
			m = (i == 3) ? 2'h0 : 2'(i + 1);
			if (m == 2'h3) p = {p[21], p[20:0] + 21'h000001};
			a = p;
			w(OFS_TABLE_OP, {6'h00, m});
			if (m == 2'h1) p = {p[21], p[20:0] + 21'h000001};
			if (m == 2'h2) p = {p[21], p[20:0] - 21'h000001};
			r(OFS_TABLE_LATCH, a[0] ? {a[21], a[7:1]} : {~a[21], a[7:1]});
			r(OFS_TABLE_POINTER_UPPER, {2'h0, p[21:16]});
			r(OFS_TABLE_POINTER_HIGH, p[15:8]);
			r(OFS_TABLE_POINTER_LOW, p[7:0]);
		end
	endtask : t_fetch
	task t_program;
		set_ptr(22'h000400);
		for (int i = 0; i < 64; i++) begin
			w(OFS_TABLE_LATCH, 8'(i) + 8'h10);
			w(OFS_TABLE_OP, 8'h05);
		end
		w(OFS_FLASH_CONTROL, 8'h04);
		unlock();
		w(OFS_FLASH_CONTROL, 8'h06);
		r(OFS_FLASH_CONTROL, 8'h04);
		check({16'h0000, wr_count}, 32'h00000040);
		check({10'h000, last_addr}, 32'h0000047F);
		check({24'h000000, last_data}, 32'h0000004F);
		w(OFS_TABLE_POINTER_LOW, 8'h47);
		w(OFS_FLASH_CONTROL, 8'h24);
		unlock();
		w(OFS_FLASH_CONTROL, 8'h26);
		r(OFS_FLASH_CONTROL, 8'h24);
		check({16'h0000, wr_count}, 32'h00000042);
		check({10'h000, last_addr}, 32'h00000447);
		check({24'h000000, last_data}, 32'h00000017);
	endtask : t_program
	task t_erase;
		set_ptr(22'h0007FF);
		w(OFS_FLASH_CONTROL, 8'h14);
		unlock();
		w(OFS_FLASH_CONTROL, 8'h16);
		r(OFS_FLASH_CONTROL, 8'h04);
		check({16'h0000, erase_count}, 32'h00000001);
		check({10'h000, erase_addr}, 32'h00000400);
	endtask : t_erase
	task t_fault;
		w(OFS_FLASH_CONTROL, 8'h06);
		r(OFS_FLASH_CONTROL, 8'h0C);
		w(OFS_FLASH_CONTROL, 8'h00);
		unlock();
		w(OFS_FLASH_CONTROL, 8'h02);
		r(OFS_FLASH_CONTROL, 8'h08);
		check({16'h0000, wr_count}, 32'h00000042);
		w(OFS_FLASH_CONTROL, 8'h14);
		unlock();
		w(OFS_FLASH_CONTROL, 8'h16);
		@(posedge mclk);
		core_reset <= 1'b1;
		repeat (2) @(posedge mclk);
		core_reset <= 1'b0;
		r(OFS_FLASH_CONTROL, 8'h08);
	endtask : t_fault
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		t_regs();
		t_fetch();
		t_program();
		t_erase();
		t_fault();
		results();
	end
endmodule : pfta_bench
